// *** squib_diag_command_decoder.sv ***
// device end: serial diagnostic and counter programming command decoder
`timescale 1ns/1ps
`include "squib_diag_regs.svh"
// Summary of operation
// - C8 reports type, resistor health, permit pins
// - C9 reports the two return low flags
// - D0-D3 return loop resistance codes
// - E0-E3 return per-loop short matrices
// - E8 returns cross-chip short flags
// - 3x pulses per-loop measurement resets
// - 3x response echoes the reset byte
// - 80 arms permit one counter, echoed
// - next byte loads permit one counter
// - response carries the loaded counter value
// - 81 arms permit two counter, echoed
// - responses shift out on the next frame
// - value byte ignored while any driver fires
// - value byte must follow unlock directly
module squib_diag_command_decoder (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    squib_diag_if.device                   link,
    input  wire logic                      part_type,
    input  wire logic                      limit_two_ok,
    input  wire logic                      limit_one_ok,
    input  wire logic                      diag_reference_resistor_ok,
    input  wire logic                      permit_two_latched,
    input  wire logic                      permit_one_latched,
    input  wire logic                      fire_permit_pin_two,
    input  wire logic                      fire_permit_pin_one,
    input  wire logic                      return_two_low_flag,
    input  wire logic                      return_one_low_flag,
    input  wire squib_diag_pkg::byte_t     res_loop_a1,
    input  wire squib_diag_pkg::byte_t     res_loop_b1,
    input  wire squib_diag_pkg::byte_t     res_loop_a2,
    input  wire squib_diag_pkg::byte_t     res_loop_b2,
    input  wire squib_diag_pkg::loop_mask_t short_loop_a1,
    input  wire squib_diag_pkg::loop_mask_t short_loop_b1,
    input  wire squib_diag_pkg::loop_mask_t short_loop_a2,
    input  wire squib_diag_pkg::loop_mask_t short_loop_b2,
    input  wire squib_diag_pkg::loop_mask_t cross_short,
    input  wire logic                      any_driver_firing,
    output logic [3:0]                     meas_reset_q,
    output squib_diag_pkg::byte_t          permit_one_counter_q,
    output squib_diag_pkg::byte_t          permit_two_counter_q
);
    import squib_diag_pkg::*;

    logic [1:0] sclk_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] mosi_sync_q;
    logic       sclk_prev_q;
    logic       cs_prev_q;
    logic       rise;
    logic       fall;
    logic       frame_end;
    byte_t      shift_in_q;
    byte_t      shift_out_q;
    byte_t      resp_q;
    logic [3:0] bit_cnt_q;
    logic       miso_q;
    arm_e       arm_q;
    byte_t      cmd;
    logic       frame_ok;
    logic [1:0] firing_sync_q;
    logic [9:0] flags_meta_q;
    logic [9:0] flags_q;
    byte_t      res_meta_q [4];
    byte_t      res_q [4];
    loop_mask_t short_meta_q [5];
    loop_mask_t short_q [5];

    // response of a code: unknown codes answer zero
    function automatic byte_t lookup(input byte_t c);
        byte_t r;
        r = 8'h00;
        unique case (c)
            `CMD_ENABLE_STATUS: r = flags_q[9:2];
            `CMD_RETURN_STATUS: r = {6'h00, flags_q[1:0]};
            `CMD_RES_A1: r = res_q[0];
            `CMD_RES_B1: r = res_q[1];
            `CMD_RES_A2: r = res_q[2];
            `CMD_RES_B2: r = res_q[3];
            `CMD_SHORT_A1: r = {4'h0, short_q[0]};
            `CMD_SHORT_B1: r = {4'h0, short_q[1]};
            `CMD_SHORT_A2: r = {4'h0, short_q[2]};
            `CMD_SHORT_B2: r = {4'h0, short_q[3]};
            `CMD_CROSS_SHORT: r = {4'h0, short_q[4]};
            `CMD_UNLOCK_ONE: r = c;
            `CMD_UNLOCK_TWO: r = c;
            default: begin
                if (c[7:4] == `CMD_MEAS_RESET_HI) begin
                    r = c;
                end
            end
        endcase
        return r;
    endfunction

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_sync_q <= 2'b00;
            cs_sync_q   <= 2'b11;
            mosi_sync_q <= 2'b00;
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
            firing_sync_q <= 2'b00;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], link.sclk};
            cs_sync_q   <= {cs_sync_q[0], link.cs_n};
            mosi_sync_q <= {mosi_sync_q[0], link.mosi};
            sclk_prev_q <= sclk_sync_q[1];
            cs_prev_q   <= cs_sync_q[1];
            firing_sync_q <= {firing_sync_q[0], any_driver_firing};
        end
    end

    // status levels from the analogue side pass two flops before the lookup reads them;
    // they are quasi-static, so a code caught mid-change is torn for one answer at most
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_meta_q <= 10'h000;
            flags_q      <= 10'h000;
            res_meta_q   <= '{default: 8'h00};
            res_q        <= '{default: 8'h00};
            short_meta_q <= '{default: 4'h0};
            short_q      <= '{default: 4'h0};
        end else begin
            flags_meta_q <= {part_type, limit_two_ok, limit_one_ok, diag_reference_resistor_ok,
                             permit_two_latched, permit_one_latched, fire_permit_pin_two, fire_permit_pin_one,
                             return_two_low_flag, return_one_low_flag};
            flags_q      <= flags_meta_q;
            res_meta_q   <= '{res_loop_a1, res_loop_b1, res_loop_a2, res_loop_b2};
            res_q        <= res_meta_q;
            short_meta_q <= '{short_loop_a1, short_loop_b1, short_loop_a2, short_loop_b2, cross_short};
            short_q      <= short_meta_q;
        end
    end

    assign rise      = ~cs_sync_q[1] & sclk_sync_q[1] & ~sclk_prev_q;
    assign fall      = ~cs_sync_q[1] & ~sclk_sync_q[1] & sclk_prev_q;
    assign frame_end = cs_sync_q[1] & ~cs_prev_q;
    assign cmd       = shift_in_q;
    assign frame_ok  = frame_end && (bit_cnt_q == `FRAME_BITS);

    // shifting: sample on rising sclk, change miso on falling, msb first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_in_q  <= 8'h00;
            shift_out_q <= 8'h00;
            bit_cnt_q   <= 4'd0;
            miso_q      <= 1'b0;
        end else if (~cs_sync_q[1] & cs_prev_q) begin
            // load previous response at frame start
            shift_out_q <= {resp_q[6:0], 1'b0};
            miso_q      <= resp_q[7];
            bit_cnt_q   <= 4'd0;
        end else if (rise) begin
            shift_in_q <= {shift_in_q[6:0], mosi_sync_q[1]};
            if (bit_cnt_q != 4'd15) begin
                bit_cnt_q <= bit_cnt_q + 4'd1;
            end
        end else if (fall) begin
            miso_q      <= shift_out_q[7];
            shift_out_q <= {shift_out_q[6:0], 1'b0};
        end
    end

    assign link.miso = miso_q;

    // command decode at frame end; short frames are dropped whole
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_q               <= 8'h00;
            arm_q                <= ARM_NONE;
            meas_reset_q         <= 4'h0;
            permit_one_counter_q <= `COUNTER_RESET;
            permit_two_counter_q <= `COUNTER_RESET;
        end else begin
            meas_reset_q <= 4'h0;
            if (frame_ok) begin
                arm_q <= ARM_NONE;
                // value byte only right after unlock
                if (arm_q != ARM_NONE) begin
                    if (firing_sync_q[1]) begin
                        resp_q <= 8'h00;
                    end else if (arm_q == ARM_ONE) begin
                        permit_one_counter_q <= cmd;
                        resp_q               <= cmd;
                    end else begin
                        permit_two_counter_q <= cmd;
                        resp_q               <= cmd;
                    end
                end else begin
                    resp_q <= lookup(cmd);
                    if (cmd == `CMD_UNLOCK_ONE) begin
                        arm_q <= ARM_ONE;
                    end else if (cmd == `CMD_UNLOCK_TWO) begin
                        arm_q <= ARM_TWO;
                    end else if (cmd[7:4] == `CMD_MEAS_RESET_HI) begin
                        meas_reset_q <= cmd[3:0];
                    end
                end
            end
        end
    end
endmodule

// *** squib_diag_regs.svh ***
// command codes, field positions and timing counts of the diagnostic command port
`ifndef SQUIB_DIAG_REGS_SVH
`define SQUIB_DIAG_REGS_SVH

`define CMD_NOP            8'h00
`define CMD_ENABLE_STATUS  8'hC8
`define CMD_RETURN_STATUS  8'hC9
`define CMD_RES_A1         8'hD0
`define CMD_RES_B1         8'hD1
`define CMD_RES_A2         8'hD2
`define CMD_RES_B2         8'hD3
`define CMD_SHORT_A1       8'hE0
`define CMD_SHORT_B1       8'hE1
`define CMD_SHORT_A2       8'hE2
`define CMD_SHORT_B2       8'hE3
`define CMD_CROSS_SHORT    8'hE8
`define CMD_UNLOCK_ONE     8'h80
`define CMD_UNLOCK_TWO     8'h81
`define CMD_MEAS_RESET_HI  4'h3
`define PART_TYPE_BIT      1'b1
`define COUNTER_RESET      8'h00
`define FRAME_BITS         4'd8
`define SYS_CLK_MHZ        200
`define LINK_PERIOD_NS     80
`define LINK_HALF_CYCLES   ((`LINK_PERIOD_NS * `SYS_CLK_MHZ) / 2000)

`endif

// *** squib_diag_pkg.sv ***
// types shared by both ends of the diagnostic command link
package squib_diag_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] loop_mask_t;
    typedef enum logic [1:0] {
        ARM_NONE,
        ARM_ONE,
        ARM_TWO
    } arm_e;
endpackage

// *** squib_diag_if.sv ***
// serial link between host controller and diagnostic command decoder
`timescale 1ns/1ps
interface squib_diag_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sclk, output cs_n, output mosi, input miso);
    modport device (input sclk, input cs_n, input mosi, output miso);
endinterface

// *** squib_diag_host.sv ***
// host end: issues one 8-bit frame per request and returns the byte shifted back
`timescale 1ns/1ps
`include "squib_diag_regs.svh"
module squib_diag_host (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    squib_diag_if.host                 link,
    input  wire logic                  req,
    input  wire squib_diag_pkg::byte_t tx_byte,
    output logic                       busy_q,
    output logic                       done_q,
    output squib_diag_pkg::byte_t      rx_byte_q
);
    import squib_diag_pkg::*;

    typedef enum logic [1:0] {
        IDLE,
        SETUP,
        SHIFT,
        HOLD
    } host_state_e;

    localparam int HALF = `LINK_HALF_CYCLES;

    host_state_e state_q;
    logic [7:0]  div_q;
    logic        tick;
    logic [3:0]  bits_q;
    byte_t       tx_q;
    logic        sclk_q;
    logic        cs_n_q;
    logic [1:0]  miso_sync_q;

    assign tick      = (div_q == 8'(HALF - 1));
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.mosi = tx_q[7];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            miso_sync_q <= 2'b00;
        end else begin
            miso_sync_q <= {miso_sync_q[0], link.miso};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
        end else if (state_q == IDLE || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // each frame returns the answer to the one before
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q   <= IDLE;
            bits_q    <= 4'd0;
            tx_q      <= 8'h00;
            sclk_q    <= 1'b0;
            cs_n_q    <= 1'b1;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    if (req) begin
                        tx_q    <= tx_byte;
                        cs_n_q  <= 1'b0;
                        busy_q  <= 1'b1;
                        bits_q  <= 4'd0;
                        state_q <= SETUP;
                    end
                end
                SETUP: begin
                    if (tick) begin
                        sclk_q  <= 1'b1;
                        state_q <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (tick) begin
                        if (sclk_q) begin
                            // sample late in the high phase to cover synchroniser delay
                            rx_byte_q <= {rx_byte_q[6:0], miso_sync_q[1]};
                            sclk_q    <= 1'b0;
                            bits_q    <= bits_q + 4'd1;
                            if (bits_q == `FRAME_BITS - 4'd1) begin
                                state_q <= HOLD;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                            end
                        end else begin
                            sclk_q <= 1'b1;
                        end
                    end
                end
                HOLD: begin
                    // keep select low for one more half period after the last falling clock
                    if (tick) begin
                        cs_n_q  <= 1'b1;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// *** squib_diag_chk.sv ***
// wire-level checks on the diagnostic link between host and decoder
`timescale 1ns/1ps
module squib_diag_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [3:0] rises_q;
    logic       sclk_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) sclk_q <= 1'b0;
        else sclk_q <= sclk;
    end
    // rising link edges seen inside the current frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) rises_q <= 4'h0;
        else if (cs_n) rises_q <= 4'h0;
        else if (sclk && !sclk_q) rises_q <= rises_q + 4'h1;
    end
    a_eight_bits: assert property ($rose(cs_n) |-> rises_q == 4'h8)
        else $error("frame closed without eight clocks");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("link clock runs outside a frame");
    a_mosi_hold: assert property (!cs_n && sclk |-> $stable(mosi))
        else $error("command bit moved while clock high");
    a_miso_hold: assert property (!cs_n && sclk |-> $stable(miso))
        else $error("response bit moved while clock high");
    a_clk_high: assert property ($rose(sclk) |-> sclk[*4] ##[1:16] !sclk)
        else $error("link clock high phase out of range");
    a_frame_len: assert property ($fell(cs_n) |-> ##[100:600] $rose(cs_n))
        else $error("frame length out of range");
    a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*4])
        else $error("frames too close together");
    a_lead_in: assert property ($fell(cs_n) |-> (!sclk)[*3])
        else $error("clock started with frame select");
endmodule

// *** tb_squib_diag_command_decoder.sv ***
// self-checking bench: host and decoder joined over the diagnostic link
`timescale 1ns/1ps
module tb_squib_diag_command_decoder;
    import squib_diag_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic       req     = 1'b0;
    logic       fire    = 1'b0;
    logic       busy_q;
    logic       done_q;
    byte_t      tx_byte = 8'h00;
    byte_t      rx_byte_q;
    byte_t      cnt_one;
    byte_t      cnt_two;
    byte_t      want    = 8'h00;
    byte_t      m_one   = 8'h00;
    byte_t      m_two   = 8'h00;
    logic [9:0] st      = 10'h000;
    byte_t      res [4] = '{default: 8'h00};
    loop_mask_t sh [5]  = '{default: 4'h0};
    logic [3:0] mr;
    logic [3:0] mr_seen = 4'h0;
    logic [3:0] mr_exp  = 4'h0;
    arm_e       arm     = ARM_NONE;
    byte_t      codes [11] = '{8'hC8, 8'hC9, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE8};
    int         err_total = 0;
    int         checked = 0;
    int         seed = 75;

    squib_diag_if link ();
    squib_diag_host u_squib_diag_host (.clk_sys(clk_sys), .rst(rst), .link(link.host), .req(req),
        .tx_byte(tx_byte), .busy_q(busy_q), .done_q(done_q), .rx_byte_q(rx_byte_q));
    squib_diag_command_decoder u_squib_diag_command_decoder (.clk_sys(clk_sys), .rst(rst),
        .link(link.device), .part_type(st[9]), .limit_two_ok(st[8]), .limit_one_ok(st[7]),
        .diag_reference_resistor_ok(st[6]), .permit_two_latched(st[5]), .permit_one_latched(st[4]),
        .fire_permit_pin_two(st[3]), .fire_permit_pin_one(st[2]), .return_two_low_flag(st[1]),
        .return_one_low_flag(st[0]), .res_loop_a1(res[0]), .res_loop_b1(res[1]), .res_loop_a2(res[2]),
        .res_loop_b2(res[3]), .short_loop_a1(sh[0]), .short_loop_b1(sh[1]), .short_loop_a2(sh[2]),
        .short_loop_b2(sh[3]), .cross_short(sh[4]), .any_driver_firing(fire), .meas_reset_q(mr),
        .permit_one_counter_q(cnt_one), .permit_two_counter_q(cnt_two));
    squib_diag_chk u_squib_diag_chk (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso(link.miso));

    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input byte_t got, input byte_t exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reference decoder: answer to this frame, shown on the next one
    function automatic byte_t model(input byte_t c);
        arm_e a;
        a = arm;
        arm = ARM_NONE;
        mr_exp = 4'h0;
        if (a != ARM_NONE) begin
            if (fire) return 8'h00;
            if (a == ARM_ONE) m_one = c;
            else m_two = c;
            return c;
        end
        case (c)
            8'hC8: return st[9:2];
            8'hC9: return {6'h00, st[1:0]};
            8'hD0, 8'hD1, 8'hD2, 8'hD3: return res[c[1:0]];
            8'hE0, 8'hE1, 8'hE2, 8'hE3: return {4'h0, sh[c[1:0]]};
            8'hE8: return {4'h0, sh[4]};
            8'h80: begin
                arm = ARM_ONE;
                return c;
            end
            8'h81: begin
                arm = ARM_TWO;
                return c;
            end
            default: begin
                if (c[7:4] != 4'h3) return 8'h00;
                mr_exp = c[3:0];
                return c;
            end
        endcase
    endfunction

    task automatic op(input byte_t c);
        int n;
        n = 0;
        mr_seen = 4'h0;
        req = 1'b1;
        tx_byte = c;
        while (done_q !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            if (busy_q === 1'b1) req = 1'b0;
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            $display("unexpected at %0t: frame never ended", $time);
        end
        chk(rx_byte_q, want);
        want = model(c);
        // pulses are single cycles, so gather them over the wait
        repeat (12) begin
            @(negedge clk_sys);
            mr_seen = mr_seen | mr;
        end
        chk(cnt_one, m_one);
        chk(cnt_two, m_two);
        chk({4'h0, mr_seen}, {4'h0, mr_exp});
    endtask

    task automatic rnd();
        st = 10'($random(seed));
        foreach (res[i]) res[i] = 8'($random(seed));
        foreach (sh[i]) sh[i] = 4'($random(seed));
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        // status held steady until the trailing read has shifted it back
        foreach (codes[i]) begin
            rnd();
            op(codes[i]);
            op(8'h00);
        end
        $display("test status reads done");
        for (int i = 0; i < 16; i++) op(8'h30 | 8'(i));
        $display("test measurement resets done");
        op(8'h80);
        op(8'($random(seed)));
        op(8'h5A);
        op(8'h81);
        op(8'hC8);
        fire = 1'b1;
        op(8'h80);
        op(8'h3C);
        fire = 1'b0;
        op(8'h00);
        $display("test programming done");
        // a reset in mid-run clears both counters and the pending answer
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        m_one = 8'h00;
        m_two = 8'h00;
        want = 8'h00;
        arm = ARM_NONE;
        op(8'hC9);
        op(8'h00);
        $display("test mid-run reset done");
        tally_and_finish();
    end

    // about 50 frames of about 150 cycles each; eight times that before giving up
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
endmodule
